/* File: bench/bcf_host_model.sv */
// Serial bus controller standing in for the host
`timescale 1ns/10ps
module bcf_host_model (
  input  logic mclk,
  input  logic sdaOe,
  output logic sclPin,
  output logic sdaIn
);
  import bcf_pkg::*;
  logic pullLow;
  assign sdaIn = ~(pullLow | sdaOe);  // Pull-up when released
  initial begin
    sclPin = 1'b1;
    pullLow = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask : hold
  task automatic bit_io(input logic b, output logic s);
    pullLow <= ~b;
    hold(6);
    sclPin <= 1'b1;
    hold(8);
    s = sdaIn;
    sclPin <= 1'b0;
    hold(6);
  endtask : bit_io
  task automatic start();
    pullLow <= 1'b0;
    hold(6);
    sclPin <= 1'b1;
    hold(8);
    pullLow <= 1'b1;
    hold(8);
    sclPin <= 1'b0;
    hold(6);
  endtask : start
  task automatic stop();
    pullLow <= 1'b1;
    hold(6);
    sclPin <= 1'b1;
    hold(8);
    pullLow <= 1'b0;
    hold(8);
  endtask : stop
  task automatic byte_io(input logic [7:0] tx, input logic hAck, output logic [7:0] rx,
                         output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(hAck, s);
    ack = ~s;
  endtask : byte_io
  task automatic wr(input logic [6:0] tgt, input logic [7:0] ra, input logic [15:0] v,
                    output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2, a3;
    start();
    byte_io({tgt, 1'b0}, 1'b1, rx, a0);
    byte_io(ra, 1'b1, rx, a1);
    byte_io(v[15:8], 1'b1, rx, a2);
    byte_io(v[7:0], 1'b1, rx, a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask : wr
  task automatic rd(input logic [7:0] ra, output logic [15:0] v, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2, n;
    start();
    byte_io({I2C_TARGET_ADDR, 1'b0}, 1'b1, rx, a0);
    byte_io(ra, 1'b1, rx, a1);
    start();
    byte_io({I2C_TARGET_ADDR, 1'b1}, 1'b1, rx, a2);
    byte_io(8'hFF, 1'b0, v[15:8], n);
    byte_io(8'hFF, 1'b1, v[7:0], n);
    stop();
    ok = a0 & a1 & a2;
  endtask : rd
endmodule : bcf_host_model

/* File: bench/bcf_regs_asserts.sv */
// Port checker for the backlight register block
`timescale 1ns/10ps
module bcf_regs_asserts
  import bcf_pkg::*;
(
  input logic        mclk,
  input logic        rst,
  input logic        sclPin,
  input logic        sdaOut,
  input logic        sdaOe,
  input logic        intPinN,
  input logic [3:0]  currentStateCode,
  input logic [6:0]  supplyFault,
  input logic [7:0]  converterFault,
  input logic [7:0]  stringFault,
  input logic [15:0] brightnessValue,
  input logic [11:0] stringCurrentValue,
  input logic [15:0] generalSettingsB,
  input logic        minPulseLimitOn,
  input logic        sCurveSmoothingOn,
  input logic [2:0]  ditherSel,
  input logic [2:0]  slopeDurationSel,
  input logic [1:0]  brightnessSourceSel,
  input logic [1:0]  ssRangeSel,
  input logic [1:0]  ssRateSel,
  input logic        ssPseudoRandomOn
);
  logic [14:0] fld;
  logic        anyFault;
  assign fld = {ssPseudoRandomOn, ssRateSel, ssRangeSel, brightnessSourceSel,
                slopeDurationSel, ditherSel, sCurveSmoothingOn, minPulseLimitOn};
  assign anyFault = |{supplyFault, converterFault, stringFault};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_reset_vals;
    $fell(rst) |-> intPinN && !sdaOe && brightnessValue == 16'h0000 && fld == CFG_RST[2][14:0];
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset outputs wrong");
  property p_open_drain;
    !sdaOut;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  property p_oe_edge;
    $changed(sdaOe) |-> !sclPin && !$past(sclPin);
  endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("data changed with clock high");
  property p_cfg_gate;
    $changed({brightnessValue, stringCurrentValue, generalSettingsB})
      |-> currentStateCode inside {[FSM_STANDBY:FSM_NORMAL]};
  endproperty
  a_cfg_gate: assert property (p_cfg_gate) else $error("config written outside window");
  property p_fld_gate;
    $changed(fld) |-> currentStateCode inside {[FSM_STANDBY:FSM_NORMAL]};
  endproperty
  a_fld_gate: assert property (p_fld_gate) else $error("fields written outside window");
  property p_write_timing;
    $changed(brightnessValue) |-> !sclPin;
  endproperty
  a_write_timing: assert property (p_write_timing) else $error("commit with clock high");
  property p_int_fall;
    $fell(intPinN) |-> $past(anyFault) || $past(anyFault, 2) || !$past(sclPin);
  endproperty
  a_int_fall: assert property (p_int_fall) else $error("interrupt without cause");
  property p_int_rise;
    $rose(intPinN) |-> !$past(sclPin);
  endproperty
  a_int_rise: assert property (p_int_rise) else $error("interrupt left without write");
  property p_int_hold;
    !intPinN && sclPin |=> !intPinN;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt dropped early");
endmodule : bcf_regs_asserts

bind bcf_regs bcf_regs_asserts u_chk (.mclk, .rst, .sclPin, .sdaOut, .sdaOe, .intPinN,
  .currentStateCode, .supplyFault, .converterFault, .stringFault, .brightnessValue,
  .stringCurrentValue, .generalSettingsB, .minPulseLimitOn, .sCurveSmoothingOn, .ditherSel,
  .slopeDurationSel, .brightnessSourceSel, .ssRangeSel, .ssRateSel, .ssPseudoRandomOn);

/* File: bench/tb.sv */
// Self-checking bench for the backlight register block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errTotal++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
  import bcf_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, sclPin, sdaIn, sdaOut, sdaOe, intPinN, ok;
  logic [3:0] currentStateCode = FSM_STANDBY, stringPhaseDetected = '0;
  logic [3:0] switchingRateDetected = '0, dimmingRateDetected = '0;
  logic [15:0] inputDutyValue = '0, outputDutyValue = '0, brightnessValue, generalSettingsB, v;
  logic [11:0] currentDacValue = '0, stringCurrentValue;
  logic [9:0] boostTargetValue = '0;
  logic [6:0] supplyFault = '0;
  logic [7:0] converterFault = '0, stringFault = '0;
  logic minPulseLimitOn, sCurveSmoothingOn, ssPseudoRandomOn;
  logic [2:0] ditherSel, slopeDurationSel;
  logic [1:0] brightnessSourceSel, ssRangeSel, ssRateSel;
  logic [14:0] fldSeen;
  int errTotal = 0, checked = 0;
  assign fldSeen = {ssPseudoRandomOn, ssRateSel, ssRangeSel, brightnessSourceSel, slopeDurationSel, ditherSel,
                    sCurveSmoothingOn, minPulseLimitOn};
  always #4 mclk = ~mclk;
  bcf_regs DUT (.mclk, .rst, .sclPin, .sdaIn, .sdaOut, .sdaOe, .intPinN, .currentStateCode,
    .inputDutyValue, .outputDutyValue, .currentDacValue, .boostTargetValue, .stringPhaseDetected,
    .switchingRateDetected, .dimmingRateDetected, .supplyFault, .converterFault, .stringFault,
    .brightnessValue, .stringCurrentValue, .generalSettingsB, .minPulseLimitOn, .sCurveSmoothingOn,
    .ditherSel, .slopeDurationSel, .brightnessSourceSel, .ssRangeSel, .ssRateSel, .ssPseudoRandomOn);
  bcf_host_model host (.mclk, .sdaOe, .sclPin, .sdaIn);
  function automatic logic [15:0] mexp(input logic [7:0] m);
    for (int i = 0; i < 8; i++) mexp[2*i +: 2] = {m[i], 1'b0};
  endfunction : mexp
  task automatic chk_rd(input logic [7:0] ra, input logic [15:0] e);
    host.rd(ra, v, ok);
    `CHK("rack", 1'b1, ok)
    `CHK("rdata", e, v)
  endtask : chk_rd
  task automatic do_wr(input logic [7:0] ra, input logic [15:0] d);
    host.wr(I2C_TARGET_ADDR, ra, d, ok);
    `CHK("wack", 1'b1, ok)
    repeat (8) @(posedge mclk);
  endtask : do_wr
  task automatic pulse(input logic [22:0] f);
    {stringFault, converterFault, supplyFault} <= f;
    @(posedge mclk);
    {stringFault, converterFault, supplyFault} <= '0;
    repeat (4) @(posedge mclk);
  endtask : pulse
  task automatic t_reset();
    for (int i = 0; i < NUM_CFG; i++) chk_rd(CFG_OFS[i], CFG_RST[i]);
    for (int i = 0; i < NUM_GROUPS; i++) chk_rd(MASK_OFS[i], mexp(MASK_RST[i]));
    for (int i = 0; i < NUM_GROUPS; i++) chk_rd(FLAG_OFS[i], 16'h0000);
  endtask : t_reset
  task automatic t_window();
    currentStateCode <= 4'h0;
    do_wr(8'h00, 16'h1234);
    `CHK("bright", 16'h0000, brightnessValue)
    currentStateCode <= FSM_STANDBY;
    do_wr(8'h00, 16'hFFFF);
    chk_rd(8'h00, 16'hFFFF);
    currentStateCode <= FSM_NORMAL;
    do_wr(8'h04, 16'h5A5A);
    `CHK("fields", 15'h5A5A, fldSeen)
    do_wr(8'h02, 16'h0ABC);
    `CHK("current", 12'hABC, stringCurrentValue)
    do_wr(8'h06, 16'hBEEF);
    currentStateCode <= FSM_NORMAL + 4'h1;
    do_wr(8'h06, 16'h0000);
    `CHK("cfgB", 16'hBEEF, generalSettingsB)
    currentStateCode <= FSM_STANDBY;
  endtask : t_window
  task automatic t_diag();
    {inputDutyValue, outputDutyValue} <= 32'hA5C3_3C5A;
    {currentDacValue, boostTargetValue} <= 22'h278_6B7;
    {stringPhaseDetected, switchingRateDetected, dimmingRateDetected} <= 12'h69C;
    chk_rd(OFS_IN_DUTY, 16'hA5C3);
    chk_rd(OFS_OUT_DUTY, 16'h3C5A);
    chk_rd(OFS_DAC_SNAP, 16'h09E1);
    chk_rd(OFS_BOOST_SNAP, 16'h02B7);
    chk_rd(OFS_DETECT, 16'h069C);
    do_wr(OFS_IN_DUTY, 16'h0000);
    chk_rd(OFS_IN_DUTY, 16'hA5C3);
    chk_rd(8'h20, 16'h0000);
    host.rd(OFS_STATE_SNAP, v, ok);
    `CHK("state", FSM_STANDBY, v[3:0])
  endtask : t_diag
  task automatic t_fault();
    pulse(23'h1);
    `CHK("int", 1'b0, intPinN)
    chk_rd(FLAG_OFS[0], 16'h0002);
    do_wr(FLAG_OFS[0], 16'h0002);
    chk_rd(FLAG_OFS[0], 16'h0002);
    do_wr(FLAG_OFS[0], 16'h0001);
    `CHK("int", 1'b0, intPinN)
    do_wr(FLAG_OFS[0], 16'h0003);
    `CHK("int", 1'b1, intPinN)
  endtask : t_fault
  task automatic t_mask();
    do_wr(MASK_OFS[0], 16'h0001);
    chk_rd(MASK_OFS[0], 16'hAAA8);
    pulse(23'h1);
    `CHK("int", 1'b1, intPinN)
    do_wr(MASK_OFS[0], 16'h0003);
    `CHK("int", 1'b0, intPinN)
    do_wr(MASK_OFS[0], 16'h4000);
    pulse(23'h80);
    `CHK("int", 1'b1, intPinN)
    do_wr(MASK_OFS[0], 16'hC000);
    `CHK("int", 1'b0, intPinN)
    do_wr(FLAG_OFS[0], 16'h0003);
    do_wr(FLAG_OFS[1], 16'h0003);
    `CHK("int", 1'b1, intPinN)
    pulse(23'h400000);
    `CHK("int", 1'b1, intPinN)
    chk_rd(FLAG_OFS[2], 16'h8000);
    do_wr(FLAG_OFS[2], 16'hC000);
    chk_rd(FLAG_OFS[2], 16'h0000);
  endtask : t_mask
  task automatic t_addr();
    host.wr(I2C_TARGET_ADDR + 7'h1, 8'h00, 16'h0F0F, ok);
    `CHK("nack", 1'b0, ok)
    `CHK("bright", 16'hFFFF, brightnessValue)
  endtask : t_addr
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", errTotal, checked);
    if (errTotal == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial begin
    repeat (80000) @(posedge mclk);
    errTotal++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    t_reset();
    t_window();
    t_diag();
    t_fault();
    t_mask();
    t_addr();
    conclude();
  end
endmodule : tb

/* File: verilog/bcf_pkg.sv */
// Constants and types for the backlight configuration and fault register block
package bcf_pkg;

  // ----------------------------------------------------------------
  // Serial target
  // ----------------------------------------------------------------
  localparam logic [6:0] I2C_TARGET_ADDR = 7'h2A;
  localparam logic [3:0] BYTE_BITS       = 4'h8;
  localparam logic [2:0] BIDX_TARGET     = 3'h0;
  localparam logic [2:0] BIDX_REGADDR    = 3'h1;
  localparam logic [2:0] BIDX_HIGH       = 3'h2;
  localparam logic [2:0] BIDX_LOW        = 3'h3;
  localparam logic [2:0] BIDX_EXTRA      = 3'h4;
  localparam logic [7:0] IDLE_FILL       = 8'hFF;

  typedef enum logic [2:0] {
    LK_IDLE  = 3'h0,
    LK_RECV  = 3'h1,
    LK_ACK   = 3'h3,
    LK_XMIT  = 3'h2,
    LK_TXACK = 3'h6
  } bcf_link_state_t;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam int         NUM_CFG    = 4;
  localparam int         NUM_GROUPS = 3;
  localparam int         FAULTS     = 8;
  localparam logic [7:0] CFG_OFS   [NUM_CFG]    = '{8'h00, 8'h02, 8'h04, 8'h06};
  localparam logic [7:0] MASK_OFS  [NUM_GROUPS] = '{8'h08, 8'h0A, 8'h0C};
  localparam logic [7:0] FLAG_OFS  [NUM_GROUPS] = '{8'h0E, 8'h10, 8'h12};
  localparam logic [7:0] OFS_STATE_SNAP = 8'h14;
  localparam logic [7:0] OFS_IN_DUTY    = 8'h16;
  localparam logic [7:0] OFS_OUT_DUTY   = 8'h18;
  localparam logic [7:0] OFS_DAC_SNAP   = 8'h1A;
  localparam logic [7:0] OFS_BOOST_SNAP = 8'h1C;
  localparam logic [7:0] OFS_DETECT     = 8'h1E;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CFG_RST  [NUM_CFG]    = '{16'h0000, 16'h0FFF, 16'h08A3, 16'h0000};
  localparam logic [7:0]  MASK_RST [NUM_GROUPS] = '{8'hFF, 8'hFF, 8'h7F};
  localparam int          GLOBAL_EN_SLOT = 7;

  // ----------------------------------------------------------------
  // Fields of general_settings_a
  // ----------------------------------------------------------------
  localparam int CFGA_MIN_PULSE  = 0;
  localparam int CFGA_S_CURVE    = 1;
  localparam int CFGA_DITHER_LSB = 2;
  localparam int CFGA_SLOPE_LSB  = 5;
  localparam int CFGA_SOURCE_LSB = 8;
  localparam int CFGA_RANGE_LSB  = 10;
  localparam int CFGA_RATE_LSB   = 12;
  localparam int CFGA_PSEUDO     = 14;

  // ----------------------------------------------------------------
  // Enable codes and state codes
  // ----------------------------------------------------------------
  localparam logic [1:0] EN_CODE_OFF = 2'h1;
  localparam logic [1:0] EN_CODE_ON  = 2'h3;
  localparam logic [3:0] FSM_STANDBY = 4'h2;
  localparam logic [3:0] FSM_NORMAL  = 4'h5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int MIN_PULSE_NS  = 200;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : bcf_pkg

/* File: verilog/bcf_regs.sv */
// Serial target and register file of the backlight configuration and fault block
//
// Notes on behaviour
// - Configuration writes take effect only while state code is standby through normal.
// - Interrupt pin goes active when an enabled fault is flagged.
// - Flag clears only when its status bit and clear bit are both written one.
// - Each fault enable reads back as binary 10 when enabled.
// - Writing 01 to an enable field disables, 11 enables; others leave it.
// - Global enable gates every fault off the interrupt pin.
// - Most fault enables come out of reset set.
// - Brightness register at offset zero, sixteen bits, read/write, resets zero.
// - Source select picks PWM input pin or brightness register.
// - Minimum pulse bit limits PWM pulses to 200 ns and enables dithering.
// - Dither select adds up to three bits of PWM dithering.
// - Advanced slope bit turns on S-curve smoothing of brightness.
// - Slope field sets linear ramp duration between brightness targets.
// - Two-bit field selects boost spread-spectrum range.
// - Two-bit field selects boost spread-spectrum modulation rate.
// - Enable bit makes spread-spectrum modulation pseudo-random.
// - Read-only field reports measured sixteen-bit input duty.
// - Read-only field reports sixteen-bit output PWM duty.
// - Read-only field reports twelve-bit current DAC value.
// - Read-only field reports ten-bit adaptive boost target.
// - Read-only field reports current state machine code.
// - Write is target address, register address, then two value bytes.
// - Read is target write, register address, target read, two value bytes.
// - Device answers at seven-bit target address 2A hex.
`timescale 1ns/10ps
module bcf_regs (
  input  logic                mclk,
  input  logic                rst,
  input  logic                sclPin,
  input  logic                sdaIn,
  output logic                sdaOut,
  output logic                sdaOe,
  output logic                intPinN,
  input  logic [3:0]          currentStateCode,
  input  logic [15:0]         inputDutyValue,
  input  logic [15:0]         outputDutyValue,
  input  logic [11:0]         currentDacValue,
  input  logic [9:0]          boostTargetValue,
  input  logic [3:0]          stringPhaseDetected,
  input  logic [3:0]          switchingRateDetected,
  input  logic [3:0]          dimmingRateDetected,
  input  logic [6:0]          supplyFault,
  input  logic [7:0]          converterFault,
  input  logic [7:0]          stringFault,
  output logic [15:0]         brightnessValue,
  output logic [11:0]         stringCurrentValue,
  output logic [15:0]         generalSettingsB,
  output logic                minPulseLimitOn,
  output logic                sCurveSmoothingOn,
  output logic [2:0]          ditherSel,
  output logic [2:0]          slopeDurationSel,
  output logic [1:0]          brightnessSourceSel,
  output logic [1:0]          ssRangeSel,
  output logic [1:0]          ssRateSel,
  output logic                ssPseudoRandomOn
);
  import bcf_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]      sclSync;
  logic [1:0]      sdaSync;
  logic            sclPrev;
  logic            sdaPrev;
  logic            sclRise;
  logic            sclFall;
  logic            startSeen;
  logic            stopSeen;
  bcf_link_state_t linkState;
  logic [3:0]      bitCount;
  logic [2:0]      byteIndex;
  logic [7:0]      shiftIn;
  logic [7:0]      shiftOut;
  logic            readMode;
  logic [7:0]      regAddr;
  logic [7:0]      highByte;
  logic [15:0]     readWord;
  logic            wrStrobe;
  logic [7:0]      wrAddr;
  logic [15:0]     wrData;
  logic            cfgWriteOk;
  logic [15:0]     cfgReg  [NUM_CFG];
  logic [7:0]      maskReg [NUM_GROUPS];
  logic [7:0]      flagReg [NUM_GROUPS];
  logic [7:0]      faultIn [NUM_GROUPS];
  logic            pending;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [15:0] spreadPairs(input logic [7:0] bits);
    logic [15:0] word;
    word = 16'h0000;
    for (int i = 0; i < FAULTS; i++) begin
      word[2*i+1] = bits[i];
    end
    return word;
  endfunction : spreadPairs

  function automatic logic [15:0] readValue(input logic [7:0] addr);
    logic [15:0] value;
    value = 16'h0000;
    for (int c = 0; c < NUM_CFG; c++) begin
      if (addr == CFG_OFS[c]) begin
        value = cfgReg[c];
      end
    end
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (addr == MASK_OFS[g]) begin
        value = spreadPairs(maskReg[g]);
      end
      if (addr == FLAG_OFS[g]) begin
        value = spreadPairs(flagReg[g]);
      end
    end
    unique case (addr)
      OFS_STATE_SNAP: value = {12'h000, currentStateCode};
      OFS_IN_DUTY:    value = inputDutyValue;
      OFS_OUT_DUTY:   value = outputDutyValue;
      OFS_DAC_SNAP:   value = {4'h0, currentDacValue};
      OFS_BOOST_SNAP: value = {6'h00, boostTargetValue};
      OFS_DETECT:     value = {4'h0, stringPhaseDetected, switchingRateDetected, dimmingRateDetected};
      default:        value = value;
    endcase
    return value;
  endfunction : readValue

  // ----------------------------------------------------------------
  // Pin synchronisers and bus conditions
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], sclPin};
      sdaSync <= {sdaSync[0], sdaIn};
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
    end
  end

  assign sclRise   = sclSync[1] & ~sclPrev;
  assign sclFall   = ~sclSync[1] & sclPrev;
  assign startSeen = sclSync[1] & sclPrev & sdaPrev & ~sdaSync[1];
  assign stopSeen  = sclSync[1] & sclPrev & ~sdaPrev & sdaSync[1];

  // ----------------------------------------------------------------
  // Serial target
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      linkState <= LK_IDLE;
      bitCount  <= 4'h0;
      byteIndex <= BIDX_TARGET;
      shiftIn   <= 8'h00;
      shiftOut  <= 8'h00;
      readMode  <= 1'b0;
      regAddr   <= 8'h00;
      highByte  <= 8'h00;
      readWord  <= 16'h0000;
      wrStrobe  <= 1'b0;
      wrAddr    <= 8'h00;
      wrData    <= 16'h0000;
      sdaOe     <= 1'b0;
    end else begin
      wrStrobe <= 1'b0;
      if (startSeen) begin
        linkState <= LK_RECV;
        bitCount  <= 4'h0;
        byteIndex <= BIDX_TARGET;
        sdaOe     <= 1'b0;
      end else if (stopSeen) begin
        linkState <= LK_IDLE;
        sdaOe     <= 1'b0;
      end else begin
        unique case (linkState)
          LK_IDLE: begin
            sdaOe <= 1'b0;
          end
          LK_RECV: begin
            if (sclRise && bitCount != BYTE_BITS) begin
              shiftIn  <= {shiftIn[6:0], sdaSync[1]};
              bitCount <= bitCount + 4'h1;
            end else if (sclFall && bitCount == BYTE_BITS) begin
              bitCount <= 4'h0;
              if (byteIndex == BIDX_TARGET) begin
                if (shiftIn[7:1] == I2C_TARGET_ADDR) begin
                  readMode  <= shiftIn[0];
                  readWord  <= readValue(regAddr);
                  byteIndex <= BIDX_REGADDR;
                  sdaOe     <= 1'b1;
                  linkState <= LK_ACK;
                end else begin
                  linkState <= LK_IDLE;
                end
              end else begin
                sdaOe     <= 1'b1;
                linkState <= LK_ACK;
                unique case (byteIndex)
                  BIDX_REGADDR: begin
                    regAddr   <= shiftIn;
                    byteIndex <= BIDX_HIGH;
                  end
                  BIDX_HIGH: begin
                    highByte  <= shiftIn;
                    byteIndex <= BIDX_LOW;
                  end
                  BIDX_LOW: begin
                    wrStrobe  <= 1'b1;
                    wrAddr    <= regAddr;
                    wrData    <= {highByte, shiftIn};
                    byteIndex <= BIDX_EXTRA;
                  end
                  default: begin
                    byteIndex <= BIDX_EXTRA;
                  end
                endcase
              end
            end
          end
          LK_ACK: begin
            if (sclFall) begin
              if (readMode) begin
                sdaOe     <= ~readWord[15];
                shiftOut  <= readWord[15:8];
                readWord  <= {readWord[7:0], IDLE_FILL};
                bitCount  <= 4'h1;
                linkState <= LK_XMIT;
              end else begin
                sdaOe     <= 1'b0;
                linkState <= LK_RECV;
              end
            end
          end
          LK_XMIT: begin
            if (sclFall) begin
              if (bitCount == BYTE_BITS) begin
                sdaOe     <= 1'b0;
                linkState <= LK_TXACK;
              end else begin
                sdaOe    <= ~shiftOut[6];
                shiftOut <= {shiftOut[6:0], 1'b0};
                bitCount <= bitCount + 4'h1;
              end
            end
          end
          LK_TXACK: begin
            if (sclRise) begin
              linkState <= sdaSync[1] ? LK_IDLE : LK_ACK;
            end
          end
          default: begin
            linkState <= LK_IDLE;
            sdaOe     <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    sdaOut <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  assign cfgWriteOk = (currentStateCode >= FSM_STANDBY) && (currentStateCode <= FSM_NORMAL);

  generate
    for (genvar c = 0; c < NUM_CFG; c++) begin : gCfg
      always_ff @(posedge mclk) begin
        if (rst) begin
          cfgReg[c] <= CFG_RST[c];
        end else if (wrStrobe && cfgWriteOk && wrAddr == CFG_OFS[c]) begin
          cfgReg[c] <= wrData;
        end
      end
    end
  endgenerate

  assign brightnessValue     = cfgReg[0];
  assign stringCurrentValue  = cfgReg[1][11:0];
  assign generalSettingsB    = cfgReg[3];
  assign minPulseLimitOn     = cfgReg[2][CFGA_MIN_PULSE];
  assign sCurveSmoothingOn   = cfgReg[2][CFGA_S_CURVE];
  assign ditherSel           = cfgReg[2][CFGA_DITHER_LSB +: 3];
  assign slopeDurationSel    = cfgReg[2][CFGA_SLOPE_LSB +: 3];
  assign brightnessSourceSel = cfgReg[2][CFGA_SOURCE_LSB +: 2];
  assign ssRangeSel          = cfgReg[2][CFGA_RANGE_LSB +: 2];
  assign ssRateSel           = cfgReg[2][CFGA_RATE_LSB +: 2];
  assign ssPseudoRandomOn    = cfgReg[2][CFGA_PSEUDO];

  // ----------------------------------------------------------------
  // Fault enables and flags
  // ----------------------------------------------------------------
  assign faultIn[0] = {1'b0, supplyFault};
  assign faultIn[1] = converterFault;
  assign faultIn[2] = stringFault;

  generate
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : gGroup
      for (genvar i = 0; i < FAULTS; i++) begin : gFault
        always_ff @(posedge mclk) begin
          if (rst) begin
            maskReg[g][i] <= MASK_RST[g][i];
          end else if (wrStrobe && cfgWriteOk && wrAddr == MASK_OFS[g]) begin
            if (wrData[2*i+1 -: 2] == EN_CODE_ON) begin
              maskReg[g][i] <= 1'b1;
            end else if (wrData[2*i+1 -: 2] == EN_CODE_OFF) begin
              maskReg[g][i] <= 1'b0;
            end
          end
        end

        always_ff @(posedge mclk) begin
          if (rst) begin
            flagReg[g][i] <= 1'b0;
          end else if (faultIn[g][i]) begin
            flagReg[g][i] <= 1'b1;
          end else if (wrStrobe && wrAddr == FLAG_OFS[g] && wrData[2*i+1] && wrData[2*i]) begin
            flagReg[g][i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------
  assign pending = |(flagReg[0] & maskReg[0]) | |(flagReg[1] & maskReg[1]) | |(flagReg[2] & maskReg[2]);

  always_ff @(posedge mclk) begin
    if (rst) begin
      intPinN <= 1'b1;
    end else begin
      intPinN <= ~(pending & maskReg[0][GLOBAL_EN_SLOT]);
    end
  end

endmodule : bcf_regs
